/* rtl/gpcfg_top.v */
// Notes on behaviour
// - Mode codes with low bits 00 leave the pin in its functional input role.
// - Mode codes with low bits 10 put the pin in high impedance, undriven.
// - Mode 001 drives the pin from the locally held output value.
// - Mode 011 makes the pin an input whose level is readable as status.
// - Mode 101 drives the remote value and keeps the last one on link loss.
// - Mode 111 drives the remote value and falls back to the local value.
// - The local value reaches a link pin in local output mode, and in mode 111 while the link is down.
// - With port select set, the first four pin fields address port two.
// - Pin 0 at 0x0D, pins 1 and 2 at 0x0E, pin 3 at 0x0F, mode low value 3.
// - Register-only pins decode 00 func, 10 hi-z, 01 output, 11 input.
// - A register-only pin outputs its value bit whenever in output mode.
// - Register-only pins pack two per register, modes 1:0 and 5:4.
// - All configuration registers reset to zero.
// - Read-only status bits report each pin's sampled input level.
// - Link detect is kept per port and its loss drives the remote modes.
`timescale 1ns/1ps
`default_nettype none
`include "gpcfg_consts.vh"

module gpcfg_top #(
    // arbitrary revision value
    parameter [3:0] REVISION = 4'h1
) (
    input  wire       i_clk,
    input  wire       i_rst_b,
    input  wire [7:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    input  wire       i_reg_wr,
    input  wire       i_reg_rd,
    output reg  [7:0] o_reg_rdata_q,
    output reg        o_reg_rvalid_q,
    input  wire       i_link_detect_p0,
    input  wire       i_link_detect_p1,
    input  wire [3:0] i_remote_val_p0,
    input  wire [3:0] i_remote_val_p1,
    input  wire [3:0] i_link_pin_in,
    output reg  [3:0] o_link_pin_out_q,
    output reg  [3:0] o_link_pin_oe_q,
    input  wire [3:0] i_second_port_pin_in,
    output reg  [3:0] o_second_port_pin_out_q,
    output reg  [3:0] o_second_port_pin_oe_q,
    input  wire [3:0] i_local_pin_in,
    output reg  [3:0] o_local_pin_out_q,
    output reg  [3:0] o_local_pin_oe_q,
    output reg        o_second_port_select_q
);

    localparam NPIN = 12;

    // per port: pin0 nibble, pins1/2 byte, pin3 nibble
    reg  [3:0] p0_pin0_q;
    reg  [7:0] p0_pin12_q;
    reg  [3:0] p0_pin3_q;
    reg  [3:0] p1_pin0_q;
    reg  [7:0] p1_pin12_q;
    reg  [3:0] p1_pin3_q;
    reg  [7:0] loc56_q;
    reg  [7:0] loc78_q;
    reg  [7:0] held_q;
    reg  [7:0] rdata_d;

    wire [NPIN-1:0] pin_lvl;
    wire [NPIN-1:0] cell_out;
    wire [NPIN-1:0] cell_oe;
    wire [3*NPIN-1:0] mode_all;
    wire [NPIN-1:0] val_all;
    wire [NPIN-1:0] link_all;
    wire [NPIN-1:0] rem_all;
    wire [NPIN-1:0] held_all;
    wire            wr_sel;
    wire            link_sel;
    wire [3:0]      lvl_sel;

    // nibble of a 4-bit config into {value, mode3}
    function [3:0] link_nib;
        input [3:0] nib;
        begin
            link_nib = nib;
        end
    endfunction

    // register-only pin nibble: 2-bit mode widened with a zero msb
    function [3:0] loc_nib;
        input [3:0] nib;
        begin
            loc_nib = {nib[`GPCFG_VAL_BIT], 1'b0, nib[1:0]};
        end
    endfunction

    // port-one copy when port select is set, else port zero
    function [3:0] pick_nib;
        input       sel;
        input [3:0] one;
        input [3:0] zero;
        begin
            pick_nib = sel ? one : zero;
        end
    endfunction

    // byte-wide form of the same pick
    function [7:0] pick_byte;
        input       sel;
        input [7:0] one;
        input [7:0] zero;
        begin
            pick_byte = sel ? one : zero;
        end
    endfunction

    gpcfg_sync #(
        .W (NPIN)
    ) u_sync (
        .i_clk      (i_clk),
        .i_rst_b    (i_rst_b),
        .i_async    ({i_local_pin_in, i_second_port_pin_in, i_link_pin_in}),
        .o_stable_q (pin_lvl)
    );

    assign wr_sel   = o_second_port_select_q;
    assign link_sel = wr_sel ? i_link_detect_p1 : i_link_detect_p0;
    assign lvl_sel  = pick_nib(wr_sel, pin_lvl[7:4], pin_lvl[3:0]);

    // mode/value vectors in pin order: port0 0..3, port1 0..3, local 5..8
    assign {val_all[0],  mode_all[2:0]}   = link_nib(p0_pin0_q);
    assign {val_all[1],  mode_all[5:3]}   = link_nib(p0_pin12_q[3:0]);
    assign {val_all[2],  mode_all[8:6]}   = link_nib(p0_pin12_q[7:4]);
    assign {val_all[3],  mode_all[11:9]}  = link_nib(p0_pin3_q);
    assign {val_all[4],  mode_all[14:12]} = link_nib(p1_pin0_q);
    assign {val_all[5],  mode_all[17:15]} = link_nib(p1_pin12_q[3:0]);
    assign {val_all[6],  mode_all[20:18]} = link_nib(p1_pin12_q[7:4]);
    assign {val_all[7],  mode_all[23:21]} = link_nib(p1_pin3_q);
    assign {val_all[8],  mode_all[26:24]} = loc_nib(loc56_q[3:0]);
    assign {val_all[9],  mode_all[29:27]} = loc_nib(loc56_q[7:4]);
    assign {val_all[10], mode_all[32:30]} = loc_nib(loc78_q[3:0]);
    assign {val_all[11], mode_all[35:33]} = loc_nib(loc78_q[7:4]);

    assign link_all = {4'h0, {4{i_link_detect_p1}}, {4{i_link_detect_p0}}};
    // remote values from the back channel
    assign rem_all  = {4'h0, i_remote_val_p1, i_remote_val_p0};
    assign held_all = {4'h0, held_q};

    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_pin
            gpcfg_pin_cell u_cell (
                .i_mode    (mode_all[3*g+2:3*g]),
                .i_value   (val_all[g]),
                .i_link_up (link_all[g]),
                .i_remote  (rem_all[g]),
                .i_held    (held_all[g]),
                .o_out     (cell_out[g]),
                .o_oe      (cell_oe[g])
            );
        end
    endgenerate

    // capture while the link is up
    // a dropped link freezes the copy, so hold mode never
    // shows what the back channel carries while it is down
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            held_q <= 8'h00;
        end else begin
            held_q[3:0] <= i_link_detect_p0 ? i_remote_val_p0 : held_q[3:0];
            held_q[7:4] <= i_link_detect_p1 ? i_remote_val_p1 : held_q[7:4];
        end
    end

    // pin drive registered so outputs come from flops;
    // costs a cycle but keeps decode glitches off the pins
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_link_pin_out_q        <= 4'h0;
            o_link_pin_oe_q         <= 4'h0;
            o_second_port_pin_out_q <= 4'h0;
            o_second_port_pin_oe_q  <= 4'h0;
            o_local_pin_out_q       <= 4'h0;
            o_local_pin_oe_q        <= 4'h0;
        end else begin
            // local pins never see remote control
            o_link_pin_out_q        <= cell_out[3:0];
            o_link_pin_oe_q         <= cell_oe[3:0];
            o_second_port_pin_out_q <= cell_out[7:4];
            o_second_port_pin_oe_q  <= cell_oe[7:4];
            o_local_pin_out_q       <= cell_out[11:8];
            o_local_pin_oe_q        <= cell_oe[11:8];
        end
    end

    // register writes
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            p0_pin0_q              <= 4'h0;
            p0_pin12_q             <= `GPCFG_CFG_RESET;
            p0_pin3_q              <= 4'h0;
            p1_pin0_q              <= 4'h0;
            p1_pin12_q             <= `GPCFG_CFG_RESET;
            p1_pin3_q              <= 4'h0;
            loc56_q                <= `GPCFG_CFG_RESET;
            loc78_q                <= `GPCFG_CFG_RESET;
            o_second_port_select_q <= 1'b0;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `GPCFG_ADDR_PIN0: begin
                    if (wr_sel) begin
                        p1_pin0_q <= i_reg_wdata[3:0];
                    end else begin
                        p0_pin0_q <= i_reg_wdata[3:0];
                    end
                end
                `GPCFG_ADDR_PIN12: begin
                    if (wr_sel) begin
                        p1_pin12_q <= i_reg_wdata & `GPCFG_MASK_FULL;
                    end else begin
                        p0_pin12_q <= i_reg_wdata & `GPCFG_MASK_FULL;
                    end
                end
                `GPCFG_ADDR_PIN3: begin
                    if (wr_sel) begin
                        p1_pin3_q <= i_reg_wdata[3:0];
                    end else begin
                        p0_pin3_q <= i_reg_wdata[3:0];
                    end
                end
                `GPCFG_ADDR_LOC56: begin
                    loc56_q <= i_reg_wdata & `GPCFG_MASK_LOCAL;
                end
                `GPCFG_ADDR_LOC78: begin
                    loc78_q <= i_reg_wdata & `GPCFG_MASK_LOCAL;
                end
                `GPCFG_ADDR_PORTSEL: begin
                    o_second_port_select_q <= i_reg_wdata[`GPCFG_PORTSEL_BIT];
                end
                default: begin
                    o_second_port_select_q <= o_second_port_select_q;
                end
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        rdata_d = 8'h00;
        case (i_reg_addr)
            // link detect of the selected port
            `GPCFG_ADDR_STATUS: begin
                rdata_d = {7'h00, link_sel};
            end
            `GPCFG_ADDR_PIN0: begin
                rdata_d = {REVISION, pick_nib(wr_sel, p1_pin0_q, p0_pin0_q)};
            end
            `GPCFG_ADDR_PIN12: begin
                rdata_d = pick_byte(wr_sel, p1_pin12_q, p0_pin12_q);
            end
            `GPCFG_ADDR_PIN3: begin
                rdata_d = {4'h0, pick_nib(wr_sel, p1_pin3_q, p0_pin3_q)};
            end
            `GPCFG_ADDR_LOC56: begin
                rdata_d = loc56_q;
            end
            `GPCFG_ADDR_LOC78: begin
                rdata_d = loc78_q;
            end
            `GPCFG_ADDR_PINSTAT1: begin
                rdata_d = {pin_lvl[10:8], 1'b0, lvl_sel};
            end
            `GPCFG_ADDR_PINSTAT2: begin
                rdata_d = {7'h00, pin_lvl[11]};
            end
            `GPCFG_ADDR_PORTSEL: begin
                rdata_d = {7'h00, o_second_port_select_q};
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // read answer one cycle after the strobe
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata_q  <= 8'h00;
            o_reg_rvalid_q <= 1'b0;
        end else begin
            o_reg_rvalid_q <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata_q <= rdata_d;
            end
        end
    end

endmodule // gpcfg_top
`default_nettype wire

/* rtl/gpcfg_consts.vh */
`ifndef GPCFG_CONSTS_VH
`define GPCFG_CONSTS_VH

// register addresses
`define GPCFG_ADDR_STATUS     8'h0C
`define GPCFG_ADDR_PIN0       8'h0D
`define GPCFG_ADDR_PIN12      8'h0E
`define GPCFG_ADDR_PIN3       8'h0F
`define GPCFG_ADDR_LOC56      8'h10
`define GPCFG_ADDR_LOC78      8'h11
`define GPCFG_ADDR_PINSTAT1   8'h1C
`define GPCFG_ADDR_PINSTAT2   8'h1D
`define GPCFG_ADDR_PORTSEL    8'h1E

// writable bits of each register
`define GPCFG_MASK_NIBBLE     8'h0F
`define GPCFG_MASK_FULL       8'hFF
`define GPCFG_MASK_LOCAL      8'hBB

// reset value of every configuration register
`define GPCFG_CFG_RESET       8'h00

// field positions inside a nibble: mode low, value at bit 3
`define GPCFG_VAL_BIT         3
`define GPCFG_LO_MODE_HI      2
`define GPCFG_HI_NIB_LSB      4
`define GPCFG_PORTSEL_BIT     0

// mode codes (3-bit, local pins extend with a leading zero)
`define GPCFG_MODE_GPO        3'h1
`define GPCFG_MODE_GPI        3'h3
`define GPCFG_MODE_RHOLD      3'h5
`define GPCFG_MODE_RDFLT      3'h7

`endif

/* rtl/gpcfg_sync.v */
`timescale 1ns/1ps
`default_nettype none

module gpcfg_sync #(
    parameter W = 12
) (
    input  wire         i_clk,
    input  wire         i_rst_b,
    input  wire [W-1:0] i_async,
    output reg  [W-1:0] o_stable_q
);

    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    wire [W-1:0] differ;

    // s1 is read by s2 only
    assign differ = s2_q ^ s3_q;

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q       <= {W{1'b0}};
            s2_q       <= {W{1'b0}};
            s3_q       <= {W{1'b0}};
            o_stable_q <= {W{1'b0}};
        end else begin
            s1_q       <= i_async;
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            // a change counts only once stages two and three agree
            o_stable_q <= (~differ & s3_q) | (differ & o_stable_q);
        end
    end

endmodule // gpcfg_sync
`default_nettype wire

/* rtl/gpcfg_pin_cell.v */
`timescale 1ns/1ps
`default_nettype none
`include "gpcfg_consts.vh"

module gpcfg_pin_cell (
    input  wire [2:0] i_mode,
    input  wire       i_value,
    input  wire       i_link_up,
    input  wire       i_remote,
    input  wire       i_held,
    output reg        o_out,
    output reg        o_oe
);

    always @* begin
        o_out = 1'b0;
        o_oe  = 1'b0;
        case (i_mode)
            `GPCFG_MODE_GPO: begin
                o_out = i_value;
                o_oe  = 1'b1;
            end
            `GPCFG_MODE_GPI: begin
                o_oe = 1'b0;
            end
            `GPCFG_MODE_RHOLD: begin
                o_out = i_link_up ? i_remote : i_held;
                o_oe  = 1'b1;
            end
            `GPCFG_MODE_RDFLT: begin
                o_out = i_link_up ? i_remote : i_value;
                o_oe  = 1'b1;
            end
            default: begin
                o_oe = 1'b0;
            end
        endcase
    end

endmodule // gpcfg_pin_cell
`default_nettype wire

/* dv/gpcfg_far_end.sv */
`timescale 1ns/1ps
`default_nettype none

module gpcfg_far_end (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_up,
    input  wire logic [3:0] i_val,
    output var  logic       o_link_q,
    output var  logic [3:0] o_val_q
);
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_link_q <= 1'h0;
            o_val_q  <= 4'h0;
        end else begin
            o_link_q <= i_up;
            // released channel flips so a stale copy shows
            o_val_q  <= i_up ? i_val : ~o_val_q;
        end
    end
endmodule // gpcfg_far_end

`default_nettype wire

/* dv/gpcfg_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module gpcfg_properties (
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] o_reg_rdata_q,
    input wire logic       i_link_detect_p0,
    input wire logic [3:0] i_remote_val_p0,
    input wire logic [3:0] o_link_pin_out_q,
    input wire logic [3:0] o_link_pin_oe_q,
    input wire logic [3:0] o_second_port_pin_out_q,
    input wire logic [3:0] o_second_port_pin_oe_q,
    input wire logic [3:0] o_local_pin_out_q,
    input wire logic [3:0] o_local_pin_oe_q,
    input wire logic       o_second_port_select_q
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire       p0_wr = i_reg_wr && i_reg_addr == 8'h0D;
    wire       own_wr = p0_wr && !o_second_port_select_q;
    wire [2:0] md = i_reg_wdata[2:0];

    func_input_a:
        assert property (own_wr && md[1:0] == 2'h0 |-> ##2 !o_link_pin_oe_q[0])
        else $error("pin driven in functional input mode");
    hiz_pin_a:
        assert property (own_wr && md[1:0] == 2'h2 |-> ##2 !o_link_pin_oe_q[0])
        else $error("pin driven in high impedance mode");
    gpo_drive_a:
        assert property (own_wr && md == 3'h1 |-> ##2 o_link_pin_oe_q[0]
            && o_link_pin_out_q[0] == $past(i_reg_wdata[3], 2))
        else $error("local output value not on pin");
    gpi_mode_a:
        assert property (own_wr && md == 3'h3 |-> ##2 !o_link_pin_oe_q[0])
        else $error("pin driven in input mode");
    remote_default_a:
        assert property (own_wr && md == 3'h7 |-> ##2 o_link_pin_oe_q[0]
            && o_link_pin_out_q[0] == ($past(i_link_detect_p0) ?
            $past(i_remote_val_p0[0]) : $past(i_reg_wdata[3], 2)))
        else $error("remote default pin value wrong");
    port_redirect_a:
        assert property (p0_wr && o_second_port_select_q && md == 3'h1
            |-> ##2 o_second_port_pin_oe_q[0]
            && o_second_port_pin_out_q[0] == $past(i_reg_wdata[3], 2))
        else $error("second port pin not configured");
    local_out_a:
        assert property (i_reg_wr && i_reg_addr == 8'h10
            && i_reg_wdata[1:0] == 2'h1 |-> ##2 o_local_pin_oe_q[0]
            && o_local_pin_out_q[0] == $past(i_reg_wdata[3], 2))
        else $error("register-only pin not driven");
    reserved_zero_a:
        assert property (i_reg_rd && i_reg_addr == 8'h0F
            |=> o_reg_rdata_q[7:4] == 4'h0)
        else $error("reserved bits read nonzero");
    reset_idle_a:
        assert property ($rose(i_rst_b) |-> o_link_pin_oe_q == 4'h0
            && o_local_pin_oe_q == 4'h0 && o_second_port_pin_oe_q == 4'h0)
        else $error("pin driven right after reset");
endmodule // gpcfg_properties

bind gpcfg_top gpcfg_properties u_props (.i_clk, .i_rst_b, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata_q, .i_link_detect_p0,
    .i_remote_val_p0, .o_link_pin_out_q, .o_link_pin_oe_q,
    .o_second_port_pin_out_q, .o_second_port_pin_oe_q, .o_local_pin_out_q,
    .o_local_pin_oe_q, .o_second_port_select_q);

`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // arbitrary revision value
    localparam [3:0] REV = 4'h1;
    reg        i_clk, i_rst_b, reg_wr, reg_rd, up0, up1, e;
    reg  [7:0] addr, wdata, d, p0;
    reg  [3:0] v0, lin, sin, locin;
    reg  [2:0] m;
    reg [31:0] r;
    reg  [7:0] q [$];
    wire [7:0] rdata;
    wire       rvalid, sel, ld0, ld1;
    wire [3:0] rv0, rv1, lpo, lpe, spo, spe, opo, ope;
    integer    bad_count, compares, seed, cyc, i;

    gpcfg_top #(.REVISION(REV)) u_dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata_q(rdata), .o_reg_rvalid_q(rvalid),
        .i_link_detect_p0(ld0), .i_link_detect_p1(ld1),
        .i_remote_val_p0(rv0), .i_remote_val_p1(rv1),
        .i_link_pin_in(lin), .o_link_pin_out_q(lpo), .o_link_pin_oe_q(lpe),
        .i_second_port_pin_in(sin), .o_second_port_pin_out_q(spo),
        .o_second_port_pin_oe_q(spe), .i_local_pin_in(locin),
        .o_local_pin_out_q(opo), .o_local_pin_oe_q(ope),
        .o_second_port_select_q(sel));
    gpcfg_far_end u_far0 (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_up(up0),
        .i_val(v0), .o_link_q(ld0), .o_val_q(rv0));
    gpcfg_far_end u_far1 (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_up(up1),
        .i_val(4'hA), .o_link_q(ld1), .o_val_q(rv1));

    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end

    task chk(input [7:0] seen, input [7:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task print_verdict;
        begin
            if (q.size() != 0) bad_count = bad_count + 1;
            $display("compares %0d mismatches %0d", compares, bad_count);
            if (bad_count == 0 && compares > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // idle edge after each access keeps strobes single-assigned
    task wr_reg(input [7:0] a, input [7:0] dat);
        begin
            addr <= a;
            wdata <= dat;
            reg_wr <= 1'h1;
            @(posedge i_clk);
            reg_wr <= 1'h0;
            @(posedge i_clk);
        end
    endtask

    task rd_reg(input [7:0] a, input [7:0] exp);
        begin
            q.push_back(exp);
            addr <= a;
            reg_rd <= 1'h1;
            @(posedge i_clk);
            reg_rd <= 1'h0;
            @(posedge i_clk);
        end
    endtask

    always @(posedge i_clk) begin
        if (rvalid === 1'h1)
            chk(rdata, q.size() ? q.pop_front() : 8'hEE);
    end

    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            bad_count = bad_count + 1;
            print_verdict;
        end
    end

    initial begin
        seed = 32'hc3d2;
        bad_count = 0;
        compares = 0;
        cyc = 0;
        {i_rst_b, reg_wr, reg_rd, addr, wdata} = 19'h0;
        {up0, up1, v0, lin, sin, locin} = 18'h3_0000;
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'h1;
        @(posedge i_clk);
        for (i = 13; i < 18; i = i + 1)
            rd_reg(i[7:0], (i == 13) ? {REV, 4'h0} : 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            r = $random(seed);
            v0 <= r[11:8];
            d = r[7:0];
            d[2:0] = i[2:0];
            m = i[2:0];
            wr_reg(8'h0D, d);
            rd_reg(8'h0D, {REV, d[3:0]});
            @(negedge i_clk);
            e = m == 3'h1 || (m[0] && m[2]);
            chk({lpe[0], lpo[0] & e}, {e, e & (m[2] ? v0[0] : d[3])});
            @(posedge i_clk);
            if (m[0] && m[2]) begin
                up0 <= 1'h0;
                repeat (4) @(negedge i_clk);
                chk(lpo[0], m[1] ? d[3] : v0[0]);
                @(posedge i_clk);
                up0 <= 1'h1;
                repeat (3) @(posedge i_clk);
            end
        end
        p0 = {REV, d[3:0]};
        r = $random(seed);
        wr_reg(8'h0E, {r[7], 3'h1, r[3], 3'h1});
        wr_reg(8'h0F, {r[7:4], r[0], 3'h1});
        rd_reg(8'h0F, {4'h0, r[0], 3'h1});
        @(negedge i_clk);
        chk({lpe[3:1], lpo[3:1]}, {3'h7, r[0], r[7], r[3]});
        @(posedge i_clk);
        for (i = 0; i < 4; i = i + 1) begin
            r = $random(seed);
            d = {r[7:6], i[1:0], r[3:2], i[1:0]};
            wr_reg(8'h10, d);
            wr_reg(8'h11, d);
            rd_reg(8'h11, d & 8'hBB);
            @(negedge i_clk);
            e = i == 1;
            chk({ope, opo & ope}, {{4{e}}, {4{e}} & {2{d[7], d[3]}}});
            @(posedge i_clk);
        end
        wr_reg(8'h1E, 8'h01);
        wr_reg(8'h0D, 8'h09);
        rd_reg(8'h0D, {REV, 4'h9});
        @(negedge i_clk);
        chk({sel, spe[0], spo[0], lpe[0]}, 4'hF);
        @(posedge i_clk);
        r = $random(seed);
        lin <= r[3:0];
        sin <= r[7:4];
        locin <= r[11:8];
        up1 <= 1'h0;
        repeat (6) @(posedge i_clk);
        rd_reg(8'h1C, {r[10:8], 1'h0, r[7:4]});
        rd_reg(8'h1D, {7'h0, r[11]});
        rd_reg(8'h0C, 8'h00);
        up1 <= 1'h1;
        repeat (3) @(posedge i_clk);
        rd_reg(8'h0C, 8'h01);
        wr_reg(8'h1E, 8'h00);
        rd_reg(8'h1C, {r[10:8], 1'h0, r[3:0]});
        rd_reg(8'h0D, p0);
        rd_reg(8'h20, 8'h00);
        repeat (3) @(posedge i_clk);
        print_verdict;
    end
endmodule // testbench

`default_nettype wire
